/* rtl/comparator_control.sv */
// Purpose: control and status logic around an analog comparator core
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes: analog selections leave as registered control outputs
//
// Behaviour
// - output bit set when positive exceeds negative
// - output synchronised, lags core one-two clocks
// - mode 00 toggle, 01 reserved, 10 fall, 11 rise
// - flag set on event, cleared by vector/write-one
// - comparator_irq needs flag, enable and global enable
// - power-off bit switches core off
// - bandgap bit steers reference to positive input
// - capture bit routes output to timer capture
// - mux enable picks converter channel or pin
// - hysteresis off, or 20 mV / 50 mV
// - mux used only while converter disabled
// - control b bit 4 reads zero, touch bits zero
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module comparator_control
  import comparator_pkg::*;
(
  input wire logic clock, // 10 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic comparator_raw, // core result, async
  input wire logic vector_ack, // comparator vector executed, pulse
  output logic comparator_power_off, // core power switched off
  output logic bandgap_positive_select, // bandgap on positive input
  output logic negative_mux_enable, // converter channel on negative
  output logic [2:0] negative_channel, // converter channel number
  output logic capture_trigger, // comparator to timer capture
  output logic hysteresis_enable, // hysteresis on
  output logic hysteresis_level, // 0: 20 mV, 1: 50 mV
  output logic comparator_irq, // comparator vector request
  output logic irq // status/enable interrupt line
);
  // ---- register state ----
  logic [7:0] ctrl_b_q; // hysteresis and mux enable bits
  logic [7:0] ctrl_q; // control byte, output and flag bits unused
  logic [7:0] sys_q; // global enable, converter bits, channel
  logic event_flag_q; // comparator event flag
  logic [1:0] irq_stat_q; // sticky status for irq line
  logic [1:0] irq_en_q; // enables for irq line
  logic comparator_output_sync; // synchronised output
  logic event_pulse; // mode-matched edge
  logic any_edge; // any output edge

  // ---- bus state ----
  logic aw_held_q; // write address taken
  logic w_held_q; // write data taken
  logic [7:0] awaddr_q; // captured write address
  logic [31:0] wdata_q; // captured write data
  logic [3:0] wstrb_q; // captured strobes
  logic bvalid_q; // write response pending
  logic [1:0] bresp_q; // write response code
  logic rvalid_q; // read data pending
  logic [31:0] rdata_q; // read data
  logic [1:0] rresp_q; // read response code

  // raw core result crosses into system domain
  sync_two_ff u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(comparator_raw),
    .sync_out(comparator_output_sync)
  );

  edge_event u_edge (
    .clock(clock),
    .rst_n(rst_n),
    .level_in(comparator_output_sync),
    .mode(ctrl_q[MODE_LSB +: 2]),
    .event_pulse(event_pulse),
    .any_edge(any_edge)
  );

  // ---- write path decode ----
  function automatic logic addr_is(input logic [7:0] addr,
                                   input logic [7:0] index);
    addr_is = (addr >> ADDR_WORD_SHIFT) == index && addr[1:0] == 2'h0;
  endfunction

  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire wr_lane0 = do_write && wstrb_q[0];
  wire wr_b = wr_lane0 && addr_is(awaddr_q, CTRL_B_INDEX);
  wire wr_ctrl = wr_lane0 && addr_is(awaddr_q, CTRL_STATUS_INDEX);
  wire wr_iclr = wr_lane0 && addr_is(awaddr_q, IRQ_CLEAR_INDEX);
  wire wr_ien = wr_lane0 && addr_is(awaddr_q, IRQ_ENABLE_INDEX);
  wire wr_sys = wr_lane0 && addr_is(awaddr_q, SYSTEM_INDEX);
  wire wr_mapped = addr_is(awaddr_q, CTRL_B_INDEX) ||
                   addr_is(awaddr_q, CTRL_STATUS_INDEX) ||
                   addr_is(awaddr_q, IRQ_STATUS_INDEX) ||
                   addr_is(awaddr_q, IRQ_CLEAR_INDEX) ||
                   addr_is(awaddr_q, IRQ_ENABLE_INDEX) ||
                   addr_is(awaddr_q, SYSTEM_INDEX);
  wire [7:0] wbyte = wdata_q[7:0];

  // flag clear sources: vector acknowledge or write-one
  wire flag_clear = vector_ack ||
                    (wr_ctrl && wbyte[EVENT_FLAG_BIT]);
  // set wins over a clear in the same cycle
  wire flag_d = event_pulse | (event_flag_q & ~flag_clear);

  wire [1:0] stat_events = {any_edge, event_pulse};
  wire [1:0] stat_clear = wr_iclr ? wbyte[1:0] : 2'h0;
  wire [1:0] stat_d = stat_events | (irq_stat_q & ~stat_clear);

  // mux only wins while the converter is off
  wire mux_active = ctrl_b_q[MUX_ENABLE_BIT] &
                    ~sys_q[CONV_ENABLE_BIT];
  // request needs flag, local enable, global enable
  wire irq_req_d = flag_d & ctrl_q[IRQ_ENABLE_BIT] &
                   sys_q[GLOBAL_IE_BIT];

  // ---- axi write channels ----
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // response raised one cycle after both halves are held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---- register updates ----
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_b_q <= CTRL_B_RESET;
      ctrl_q <= CTRL_STATUS_RESET;
      sys_q <= SYSTEM_RESET;
      irq_en_q <= 2'h0;
    end else begin
      // touch bits and bit 4 are not stored, so read zero
      if (wr_b) ctrl_b_q <= wbyte & CTRL_B_WRITE_MASK;
      if (wr_ctrl) ctrl_q <= wbyte;
      if (wr_sys) sys_q <= wbyte;
      if (wr_ien) irq_en_q <= wbyte[1:0];
    end
  end

  // event flag and sticky status
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      event_flag_q <= 1'b0;
      irq_stat_q <= 2'h0;
    end else begin
      event_flag_q <= flag_d;
      irq_stat_q <= stat_d;
    end
  end

  // ---- registered outputs to the analog core, timer capture and interrupts ----
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      comparator_power_off <= 1'b0;
      bandgap_positive_select <= 1'b0;
      negative_mux_enable <= 1'b0;
      negative_channel <= 3'h0;
      capture_trigger <= 1'b0;
      hysteresis_enable <= 1'b0;
      hysteresis_level <= 1'b0;
      comparator_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      comparator_power_off <= ctrl_q[POWER_OFF_BIT];
      bandgap_positive_select <= ctrl_q[BANDGAP_BIT];
      // channels 8 and up are not comparator sources
      negative_mux_enable <= mux_active &
        ~sys_q[CHANNEL_LSB + 3];
      negative_channel <= sys_q[CHANNEL_LSB +: 3];
      // no connection while capture route is off
      capture_trigger <= ctrl_q[CAPTURE_BIT] &
                         comparator_output_sync;
      hysteresis_enable <= ctrl_b_q[HYST_SELECT_BIT];
      hysteresis_level <= ctrl_b_q[HYST_LEVEL_BIT];
      comparator_irq <= irq_req_d;
      irq <= |(stat_d & irq_en_q);
    end
  end

  // ---- read path ----
  wire [7:0] rd_ctrl = {ctrl_q[7:6], comparator_output_sync,
                        event_flag_q, ctrl_q[3:0]};
  wire [7:0] rd_b = ctrl_b_q;
  wire rd_ok = addr_is(s_axi_araddr, CTRL_B_INDEX) ||
               addr_is(s_axi_araddr, CTRL_STATUS_INDEX) ||
               addr_is(s_axi_araddr, IRQ_STATUS_INDEX) ||
               addr_is(s_axi_araddr, IRQ_CLEAR_INDEX) ||
               addr_is(s_axi_araddr, IRQ_ENABLE_INDEX) ||
               addr_is(s_axi_araddr, SYSTEM_INDEX);
  wire [7:0] rd_byte =
    addr_is(s_axi_araddr, CTRL_B_INDEX) ? rd_b :
    addr_is(s_axi_araddr, CTRL_STATUS_INDEX) ? rd_ctrl :
    addr_is(s_axi_araddr, IRQ_STATUS_INDEX) ? {6'h00, irq_stat_q} :
    addr_is(s_axi_araddr, IRQ_ENABLE_INDEX) ? {6'h00, irq_en_q} :
    addr_is(s_axi_araddr, SYSTEM_INDEX) ? sys_q : 8'h00;
  wire take_ar = s_axi_arvalid && !rvalid_q;

  // read answered in the cycle after the address is taken
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (take_ar) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ---- checks ----
  sequence raw_held;
    comparator_raw [*3];
  endsequence

  chk_sync_lag: assert property (@(posedge clock) disable iff (!rst_n)
    raw_held |-> comparator_output_sync)
    else $error("output bit does not follow core within two clocks");

  chk_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
    event_pulse |=> event_flag_q)
    else $error("event flag not set by matching edge");

  chk_flag_clear: assert property (@(posedge clock) disable iff (!rst_n)
    vector_ack && !event_pulse |=> !event_flag_q)
    else $error("event flag not cleared by vector");

  chk_irq_gate: assert property (@(posedge clock) disable iff (!rst_n)
    comparator_irq |-> $past(ctrl_q[IRQ_ENABLE_BIT])
      && $past(sys_q[GLOBAL_IE_BIT]))
    else $error("comparator request without enables");

  chk_mode_rsv: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_q[1:0] == MODE_RESERVED |-> !event_pulse)
    else $error("reserved mode produced an event");

  chk_power_off: assert property (@(posedge clock) disable iff (!rst_n)
    wr_ctrl |-> ##2 comparator_power_off == $past(wbyte[7], 2))
    else $error("power off bit not applied");

  chk_capture_off: assert property (@(posedge clock) disable iff (!rst_n)
    !ctrl_q[CAPTURE_BIT] |=> !capture_trigger)
    else $error("capture path active while routed off");

  chk_mux_conv: assert property (@(posedge clock) disable iff (!rst_n)
    sys_q[CONV_ENABLE_BIT] |=> !negative_mux_enable)
    else $error("mux on negative input while converter enabled");

  chk_bit4_zero: assert property (@(posedge clock) disable iff (!rst_n)
    !ctrl_b_q[4] && !ctrl_b_q[5] && !ctrl_b_q[3])
    else $error("reserved control b bit stored");

  chk_hyst: assert property (@(posedge clock) disable iff (!rst_n)
    hysteresis_level |-> $past(ctrl_b_q[HYST_LEVEL_BIT]))
    else $error("hysteresis level not from register");
endmodule

/* rtl/comparator_pkg.sv */
// Purpose: shared constants for the analog comparator control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: printed offsets are not multiples of four, so they are indices
package comparator_pkg;
  // register indices and the word address shift
  localparam logic [7:0] CTRL_B_INDEX = 8'h13;
  localparam logic [7:0] CTRL_STATUS_INDEX = 8'h14;
  localparam logic [7:0] IRQ_STATUS_INDEX = 8'h15;
  localparam logic [7:0] IRQ_CLEAR_INDEX = 8'h16;
  localparam logic [7:0] IRQ_ENABLE_INDEX = 8'h17;
  localparam logic [7:0] SYSTEM_INDEX = 8'h18;
  localparam logic [7:0] ADDR_WORD_SHIFT = 8'h02;
  // control/status field positions
  localparam int POWER_OFF_BIT = 7;
  localparam int BANDGAP_BIT = 6;
  localparam int OUTPUT_BIT = 5;
  localparam int EVENT_FLAG_BIT = 4;
  localparam int IRQ_ENABLE_BIT = 3;
  localparam int CAPTURE_BIT = 2;
  localparam int MODE_LSB = 0;
  // control b field positions
  localparam int HYST_SELECT_BIT = 7;
  localparam int HYST_LEVEL_BIT = 6;
  localparam int MUX_ENABLE_BIT = 2;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_WRITE_MASK = 8'hC4;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  // system register fields: global enable, converter enable, power red.
  localparam int GLOBAL_IE_BIT = 0;
  localparam int CONV_ENABLE_BIT = 1;
  localparam int CONV_PWR_RED_BIT = 2;
  localparam int CHANNEL_LSB = 4;
  localparam logic [7:0] SYSTEM_RESET = 8'h00;
  // interrupt status bit positions
  localparam int IRQ_EVENT_BIT = 0;
  localparam int IRQ_OUTPUT_BIT = 1;
  // interrupt modes
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALLING = 2'h2;
  localparam logic [1:0] MODE_RISING = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // channel count of the converter multiplexer
  localparam int CHANNELS = 8;
endpackage

/* rtl/edge_event.sv */
// Purpose: edge detection and mode match on the synchronised output
// Assumes: input already in the clock domain
// Notes: one-cycle pulse per matching edge
`timescale 1ns/1ps
module edge_event
  import comparator_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic level_in, // synchronised comparator output
  input wire logic [1:0] mode, // interrupt mode field
  output logic event_pulse, // matching edge, one cycle
  output logic any_edge // any edge, one cycle
);
  logic prev_q; // level one clock earlier
  logic rise; // rising edge
  logic fall; // falling edge

  // hold previous level for comparison
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) prev_q <= 1'b0;
    else prev_q <= level_in;
  end

  assign rise = level_in & ~prev_q;
  assign fall = ~level_in & prev_q;
  assign any_edge = rise | fall;
  // reserved mode never fires
  assign event_pulse = (mode == MODE_TOGGLE) ? any_edge :
                       (mode == MODE_FALLING) ? fall :
                       (mode == MODE_RISING) ? rise : 1'b0;
endmodule

/* rtl/sync_two_ff.sv */
// Purpose: two flip-flop level synchroniser
// Assumes: input is asynchronous to clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module sync_two_ff (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic async_in, // level from outside the domain
  output logic sync_out // synchronised level
);
  logic meta_q; // first stage, may be metastable

  // plain shift through two stages
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* sim/comparator_core_model.sv */
// Purpose: behavioural model of the analog comparator core and its inputs
// Assumes: the bench gives pin and channel voltages in millivolts
// Notes: a powered-off core drives a low result, never the last one
`timescale 1ns/1ps
module comparator_core_model #(
  parameter int BANDGAP_MV = 1000 // plain default reference level
) (
  input wire logic power_off, // core power switched off
  input wire logic bandgap_sel, // bandgap on positive input
  input wire logic mux_en, // converter channel on negative
  input wire logic [2:0] channel, // converter channel number
  input wire logic hyst_en, // hysteresis on
  input wire logic hyst_lvl, // 0: 20 mV, 1: 50 mV
  input wire logic signed [31:0] pin_pos_mv, // positive pin voltage
  input wire logic signed [31:0] pin_neg_mv, // negative pin voltage
  input wire logic signed [31:0] chan_base_mv, // channel 0, +10 mV a step
  output logic result // raw comparison, async to the clock
);
  int pos;
  int neg;
  int hyst;
  // the result only moves once the band is left, so it holds inside it
  always @* begin
    pos = bandgap_sel ? BANDGAP_MV : pin_pos_mv;
    neg = mux_en ? chan_base_mv + 10 * int'(channel) : pin_neg_mv;
    hyst = !hyst_en ? 0 : (hyst_lvl ? 50 : 20);
    if (power_off) begin
      result = 1'b0;
    end else if (pos > neg + hyst / 2) begin
      result = 1'b1;
    end else if (pos < neg - hyst / 2) begin
      result = 1'b0;
    end
  end
endmodule

/* sim/tb_top.sv */
// Purpose: self-checking bench for the comparator control block
// Assumes: AXI4-Lite master tasks, core model on the analog side
// Notes: the model answers at once, events need a few clocks to land
`timescale 1ns/1ps
module tb_top
  import comparator_pkg::*;
;
  localparam logic [7:0] A_CB = 8'(CTRL_B_INDEX * 4);
  localparam logic [7:0] A_CS = 8'(CTRL_STATUS_INDEX * 4);
  localparam logic [7:0] A_IS = 8'(IRQ_STATUS_INDEX * 4);
  localparam logic [7:0] A_IC = 8'(IRQ_CLEAR_INDEX * 4);
  localparam logic [7:0] A_IE = 8'(IRQ_ENABLE_INDEX * 4);
  localparam logic [7:0] A_SY = 8'(SYSTEM_INDEX * 4);
  logic clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, comparator_raw;
  logic vector_ack, comparator_power_off, bandgap_positive_select;
  logic negative_mux_enable, capture_trigger, hysteresis_enable;
  logic hysteresis_level, comparator_irq, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, m;
  logic [2:0] negative_channel;
  logic [31:0] d;
  int pos_mv, bad_count, n_compared;
  logic [1:0] modes [4] = '{MODE_TOGGLE, MODE_FALLING, MODE_RISING,
                            MODE_RESERVED};
  comparator_control uut (.clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .comparator_raw(comparator_raw),
    .vector_ack(vector_ack), .comparator_power_off(comparator_power_off),
    .bandgap_positive_select(bandgap_positive_select),
    .negative_mux_enable(negative_mux_enable),
    .negative_channel(negative_channel), .capture_trigger(capture_trigger),
    .hysteresis_enable(hysteresis_enable),
    .hysteresis_level(hysteresis_level), .comparator_irq(comparator_irq),
    .irq(irq));
  // negative pin sits at 500 mV, channels start at 100 mV
  comparator_core_model core (.power_off(comparator_power_off),
    .bandgap_sel(bandgap_positive_select), .mux_en(negative_mux_enable),
    .channel(negative_channel), .hyst_en(hysteresis_enable),
    .hyst_lvl(hysteresis_level), .pin_pos_mv(pos_mv), .pin_neg_mv(500),
    .chan_base_mv(100), .result(comparator_raw));
  // 100 ns period
  always #50 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // address and data offered together, each dropped once taken
  task automatic xwr(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no local limit: only the watchdog ends a wait for the answer
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xwr(a, v, RESP_OKAY);
  endtask
  // read, checking the masked word and the response code
  task automatic rdc(input logic [7:0] a, input logic [31:0] k,
                     input logic [31:0] e, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rresp), 32'(er));
    chk(s_axi_rdata & k, e);
  endtask
  // expected status word: written bits with live output and flag
  function automatic logic [31:0] sw(logic o, logic f, logic [7:0] w);
    sw = 32'(w & 8'hCF) | (32'(o) << OUTPUT_BIT) | (32'(f) << EVENT_FLAG_BIT);
  endfunction
  // watchdog: the tests need well under 3000 clocks
  initial begin
    wt(20000);
    bad_count++;
    end_sim();
  end
  initial begin
    clock = 0;
    rst_n = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, vector_ack} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    pos_mv = 0;
    bad_count = 0;
    n_compared = 0;
    wt(4);
    rst_n <= 1'b1;
    rdc(A_CB, 32'hFF, 32'(CTRL_B_RESET), RESP_OKAY);
    rdc(A_CS, 32'hFF, 32'h00, RESP_OKAY);
    // touch bits and bit 4 must never stick
    wr(A_CB, 32'hFF);
    rdc(A_CB, 32'hFF, 32'hC4, RESP_OKAY);
    chk(32'({hysteresis_enable, hysteresis_level}), 32'h3);
    // 20 mV above channel 0 stays inside the 50 mV band
    pos_mv <= 120;
    wt(4);
    rdc(A_CS, 32'h20, 32'h00, RESP_OKAY);
    wr(A_CB, 32'h84);
    wt(4);
    chk(32'({hysteresis_enable, hysteresis_level}), 32'h2);
    rdc(A_CS, 32'h20, 32'h20, RESP_OKAY);
    // power reduction left clear before the mux is used
    wr(A_SY, 32'h50);
    // outputs settle one edge after the write lands
    wt(1);
    chk(32'({negative_mux_enable, negative_channel}), 32'hD);
    wt(4);
    rdc(A_CS, 32'h20, 32'h00, RESP_OKAY);
    wr(A_SY, 32'h52);
    wt(1);
    chk(32'(negative_mux_enable), 32'h0);
    wr(A_CB, 32'h00);
    wr(A_SY, 32'h00);
    // lane 0 strobe off leaves the register alone but answers okay
    s_axi_wstrb <= 4'hE;
    wr(A_CB, 32'hFF);
    s_axi_wstrb <= 4'hF;
    rdc(A_CB, 32'hFF, 32'h00, RESP_OKAY);
    // each mode against one rise and one fall, enable kept off
    foreach (modes[i]) begin
      m = modes[i];
      wr(A_CS, 32'h10 | 32'(m));
      pos_mv <= 600;
      wt(5);
      d = sw(1'b1, m == 2'h0 || m == 2'h3, 8'(m));
      rdc(A_CS, 32'h3F, d, RESP_OKAY);
      wr(A_CS, 32'h10 | 32'(m));
      pos_mv <= 0;
      wt(5);
      d = sw(1'b0, m == 2'h0 || m == 2'h2, 8'(m));
      rdc(A_CS, 32'h3F, d, RESP_OKAY);
    end
    // request needs flag, enable and global enable together
    wr(A_CS, 32'h13);
    wr(A_SY, 32'h01);
    wr(A_CS, 32'h0B);
    pos_mv <= 600;
    wt(6);
    chk(32'(comparator_irq), 32'h1);
    vector_ack <= 1'b1;
    @(posedge clock);
    vector_ack <= 1'b0;
    wt(3);
    chk(32'(comparator_irq), 32'h0);
    rdc(A_CS, 32'h3F, sw(1, 0, 8'h0B), RESP_OKAY);
    wr(A_SY, 32'h00);
    pos_mv <= 0;
    wt(5);
    pos_mv <= 600;
    wt(6);
    chk(32'(comparator_irq), 32'h0);
    wr(A_CS, 32'h03);
    wr(A_SY, 32'h01);
    wt(2);
    chk(32'(comparator_irq), 32'h0);
    wr(A_CS, 32'h13);
    rdc(A_CS, 32'h3F, sw(1, 0, 8'h03), RESP_OKAY);
    // sticky status, enable mask and write-one clear
    wr(A_IC, 32'h03);
    rdc(A_IS, 32'h03, 32'h00, RESP_OKAY);
    wr(A_IE, 32'h02);
    pos_mv <= 0;
    wt(6);
    rdc(A_IS, 32'h03, 32'h02, RESP_OKAY);
    chk(32'(irq), 32'h1);
    wr(A_IE, 32'h00);
    wt(2);
    chk(32'(irq), 32'h0);
    wr(A_IE, 32'h02);
    wt(2);
    chk(32'(irq), 32'h1);
    wr(A_IC, 32'h02);
    wt(2);
    chk(32'(irq), 32'h0);
    rdc(A_IS, 32'h03, 32'h00, RESP_OKAY);
    // capture route follows the synchronised output only when on
    // the timer side sets its own capture irq enable
    wr(A_CS, 32'h04);
    chk(32'(capture_trigger), 32'h0);
    pos_mv <= 600;
    wt(5);
    chk(32'(capture_trigger), 32'h1);
    wr(A_CS, 32'h00);
    wt(1);
    chk(32'(capture_trigger), 32'h0);
    // bandgap beats the grounded pin; enable already off
    pos_mv <= 0;
    wr(A_CS, 32'h40);
    wt(4);
    chk(32'(bandgap_positive_select), 32'h1);
    rdc(A_CS, 32'h20, 32'h20, RESP_OKAY);
    wr(A_CS, 32'h80);
    wt(4);
    chk(32'(comparator_power_off), 32'h1);
    rdc(A_CS, 32'h20, 32'h00, RESP_OKAY);
    // unmapped places answer with an error and read zero
    xwr(8'h7C, 32'h01, RESP_SLVERR);
    rdc(8'h00, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    end_sim();
  end
endmodule
